// *** pld_defs.svh ***
/*
 * offsets, field positions, reset values and timing for the phase loss detector.
 * assumes a 100 MHz system clock and an 8-bit register port.
 */
`ifndef PLD_DEFS_SVH
`define PLD_DEFS_SVH
`define PLD_ADDR_FINE 8'h73
`define PLD_ADDR_COARSE 8'h74
`define PLD_ADDR_STAT 8'h80
`define PLD_ADDR_CLR 8'h81
`define PLD_ADDR_IEN 8'h82
`define PLD_FINE_RST 8'ha2
`define PLD_COARSE_RST 8'h85
`define PLD_FINE_EN_BIT 7
`define PLD_COARSE_EN_BIT 7
`define PLD_WIN_STEP 17'h0_0020
`define PLD_CLK_MHZ 100
`define PLD_LOCK_QUAL_MS 1000
`define PLD_LOCK_QUAL_CYC (`PLD_LOCK_QUAL_MS * 1000 * `PLD_CLK_MHZ)
`define PLD_ST_LOCK 0
`define PLD_ST_LOSS 1
`endif

// *** pld_detector.sv ***
/*
 * phase lock / phase loss qualification for the output dpll.
 * assumes the phase measurement is synchronous to clk_sys_i: fine error in
 * 1/256 of an input cycle, coarse error in whole input cycles (ui).
 */
// Implementation choice: the strobed register port.
`include "pld_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module pld_detector
  import pld_pkg::*;
#(
  parameter int unsigned LOCK_QUAL_CYCLES = `PLD_LOCK_QUAL_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire pld_meas_type meas_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  output logic locked_o,
  output logic phase_lost_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: a qualification shorter than two cycles cannot be counted
  if (LOCK_QUAL_CYCLES < 2) begin : g_bad_qual
    $error("LOCK_QUAL_CYCLES must be at least 2");
  end

  logic [7:0] fine_reg;
  logic [7:0] coarse_reg;
  logic [1:0] stat_reg;
  logic [1:0] ien_reg;
  logic [31:0] qual_reg;
  pld_state_type state_reg;
  logic [16:0] fine_mag;
  logic [16:0] ui_mag;
  logic [16:0] win_lim;
  logic fine_en;
  logic coarse_en;
  logic fine_out;
  logic coarse_out;
  logic loss_now;
  logic lock_evt;
  logic loss_evt;
  logic [1:0] clr_bits;

  ////////////////////////////////////////////////////////////////////////////
  // magnitudes; 17 bits so that the most negative error does not wrap
  assign fine_mag = meas_i.fine_err[15] ? 17'(-$signed({1'b1, meas_i.fine_err}))
                                        : {1'b0, meas_i.fine_err};
  assign ui_mag = meas_i.ui_err[15] ? 17'(-$signed({1'b1, meas_i.ui_err}))
                                    : {1'b0, meas_i.ui_err};

  // window half width: code * 45 degrees, so 010 gives 90 degrees
  assign win_lim = 17'(fine_reg[2:0] * `PLD_WIN_STEP);
  assign fine_en = fine_reg[`PLD_FINE_EN_BIT];
  assign coarse_en = coarse_reg[`PLD_COARSE_EN_BIT];
  // code 000 gives an empty window, so it reports loss whenever the fine enable is set
  assign fine_out = (fine_reg[2:0] == 3'b000) || (fine_mag > win_lim);
  // coarse limit compared against whole cycles of input
  assign coarse_out = ui_mag > {13'h0_000, coarse_reg[3:0]};
  // each detector only counts while its enable is set
  assign loss_now = (fine_en && fine_out) || (coarse_en && coarse_out);

  // window edges: the limit itself is inside, the forbidden code never is
  window_edge_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (fine_reg[2:0] != 3'b000 && fine_mag == win_lim) |-> !fine_out)
    else $error("window edge not accepted");

  code_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (fine_reg[2:0] == 3'b000) |-> fine_out)
    else $error("size code 000 accepted a phase error");

  coarse_edge_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (ui_mag == {13'h0_000, coarse_reg[3:0]} + 17'h0_0001) |-> coarse_out)
    else $error("coarse limit plus one cycle not flagged");

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; all bits stored so software reads back what it wrote
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fine_reg <= `PLD_FINE_RST;
      coarse_reg <= `PLD_COARSE_RST;
    end else if (wr_i) begin
      if (addr_i == `PLD_ADDR_FINE) begin
        fine_reg <= wr_data_i;
      end
      if (addr_i == `PLD_ADDR_COARSE) begin
        coarse_reg <= wr_data_i;
      end
    end
  end

  // a write lands on the strobe edge and nowhere else
  fine_write_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == `PLD_ADDR_FINE) |=> (fine_reg == $past(wr_data_i)))
    else $error("fine register write lost");

  coarse_write_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == `PLD_ADDR_COARSE) |=> (coarse_reg == $past(wr_data_i)))
    else $error("coarse register write lost");

  ////////////////////////////////////////////////////////////////////////////
  // lock qualifier: loss is immediate, lock needs an unbroken run
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= PLD_LOST;
      qual_reg <= 32'h0000_0000;
    end else if (loss_now) begin
      // any excursion restarts the qualification
      state_reg <= PLD_LOST;
      qual_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        PLD_LOST: begin
          state_reg <= PLD_QUAL;
          qual_reg <= 32'h0000_0001;
        end
        PLD_QUAL: begin
          // one second at the default: inside the 1 to 2 s band
          if (qual_reg >= LOCK_QUAL_CYCLES - 1) begin
            state_reg <= PLD_LOCKED;
          end else begin
            qual_reg <= qual_reg + 32'h0000_0001;
          end
        end
        PLD_LOCKED: begin
          state_reg <= PLD_LOCKED;
        end
        default: begin
          state_reg <= PLD_LOST;
        end
      endcase
    end
  end

  // qualifier: restart on loss, no early lock, counter stays bounded
  loss_restart_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    loss_now |=> (state_reg == PLD_LOST && qual_reg == 32'h0000_0000))
    else $error("loss did not restart qualification");

  qual_bound_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    qual_reg <= LOCK_QUAL_CYCLES - 1)
    else $error("qualification counter overran");

  early_lock_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == PLD_QUAL && !loss_now && qual_reg < LOCK_QUAL_CYCLES - 1)
    |=> (state_reg != PLD_LOCKED))
    else $error("lock entered before the period ended");

  lock_entry_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    lock_evt |=> (state_reg == PLD_LOCKED))
    else $error("lock not entered after the period");

  // status outputs straight from flops; loss follows the error by one cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      locked_o <= 1'b0;
      phase_lost_o <= 1'b1;
    end else begin
      locked_o <= (state_reg == PLD_LOCKED) && !loss_now;
      phase_lost_o <= loss_now;
    end
  end

  // status outputs track the detector one edge later, never both high
  loss_follow_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    loss_now |=> phase_lost_o)
    else $error("loss output did not follow the detector");

  loss_release_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !loss_now |=> !phase_lost_o)
    else $error("loss output stuck after recovery");

  lock_exclusive_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !(locked_o && phase_lost_o))
    else $error("locked and lost at once");

  locked_follow_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == PLD_LOCKED && !loss_now) |=> locked_o)
    else $error("locked output missing in lock state");

  ////////////////////////////////////////////////////////////////////////////
  // events and sticky status; a new event beats a clear in the same cycle
  assign lock_evt = (state_reg == PLD_QUAL) && !loss_now &&
                    (qual_reg >= LOCK_QUAL_CYCLES - 1);
  assign loss_evt = loss_now && (state_reg != PLD_LOST);
  assign clr_bits = (wr_i && addr_i == `PLD_ADDR_CLR) ? wr_data_i[1:0] : 2'b00;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stat_reg <= 2'b00;
    end else begin
      stat_reg[`PLD_ST_LOCK] <= lock_evt || (stat_reg[`PLD_ST_LOCK] && !clr_bits[0]);
      stat_reg[`PLD_ST_LOSS] <= loss_evt || (stat_reg[`PLD_ST_LOSS] && !clr_bits[1]);
    end
  end

  // sticky bits: lock is captured, a clear with no new event empties
  lock_capture_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    lock_evt |=> stat_reg[`PLD_ST_LOCK])
    else $error("lock event not captured in status");

  loss_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (clr_bits[1] && !loss_evt) |=> !stat_reg[`PLD_ST_LOSS])
    else $error("loss status not cleared");

  // interrupt enable register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ien_reg <= 2'b00;
    end else if (wr_i && addr_i == `PLD_ADDR_IEN) begin
      ien_reg <= wr_data_i[1:0];
    end
  end

  // enable write lands on the strobe edge
  ien_write_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == `PLD_ADDR_IEN) |=> (ien_reg == $past(wr_data_i[1:0])))
    else $error("enable register write lost");

  // level interrupt, registered so the output is glitch free
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_reg & ien_reg);
    end
  end

  // level interrupt one edge behind the enabled status
  irq_raise_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (|(stat_reg & ien_reg)) |=> irq_o)
    else $error("interrupt not raised");

  irq_drop_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !(|(stat_reg & ien_reg)) |=> !irq_o)
    else $error("interrupt not dropped");

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stands in the cycle after the strobe only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `PLD_ADDR_FINE: rd_data_o <= fine_reg;
        `PLD_ADDR_COARSE: rd_data_o <= coarse_reg;
        `PLD_ADDR_STAT: rd_data_o <= {6'h00, stat_reg};
        `PLD_ADDR_IEN: rd_data_o <= {6'h00, ien_reg};
        default: rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // read data stands for one cycle only, then returns to zero
  read_idle_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !rd_i |=> (rd_data_o == 8'h00))
    else $error("read data without a read strobe");

  fine_readback_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == `PLD_ADDR_FINE) |=> (rd_data_o == $past(fine_reg)))
    else $error("fine register read back wrong");

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic past_rst;
  always_ff @(posedge clk_sys_i) begin
    past_rst <= rst_i;
  end

  reset_value_a: assert property (
    @(posedge clk_sys_i) (past_rst && !rst_i) |-> (fine_reg == 8'ha2))
    else $error("fine window register reset value wrong");

  default_window_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (fine_reg[2:0] == 3'b010) |-> (fine_out == (fine_mag > 17'h0_0040)))
    else $error("default window not 90 degrees");

  lock_qualify_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(locked_o) |-> $past(qual_reg) >= LOCK_QUAL_CYCLES - 1)
    else $error("lock declared before qualification ended");

  fine_loss_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (fine_en && fine_out) |=> (phase_lost_o && !locked_o))
    else $error("fine excursion did not flag loss at once");

  window_scale_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    win_lim == {9'h000, fine_reg[2:0], 5'h00})
    else $error("window not proportional to size code");

  coarse_off_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (!coarse_en && !(fine_en && fine_out)) |=> !phase_lost_o)
    else $error("disabled coarse detector caused loss");

  coarse_loss_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (coarse_en && ui_mag > {13'h0_000, coarse_reg[3:0]}) |=> phase_lost_o)
    else $error("coarse excursion did not flag loss");

  coarse_units_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (ui_mag == {13'h0_000, coarse_reg[3:0]}) |-> !coarse_out)
    else $error("coarse limit not counted in whole cycles");

  fine_off_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (!fine_en && !(coarse_en && coarse_out)) |=> !phase_lost_o)
    else $error("disabled fine window caused loss");

  sticky_set_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    loss_evt |=> stat_reg[`PLD_ST_LOSS])
    else $error("loss event not captured in status");

endmodule // pld_detector
`default_nettype wire

// *** pld_detector_tb.sv ***
/*
 * self-checking bench of the phase loss detector: registers, windows, lock, irq.
 * assumes the defines header and the package are compiled before this file.
 */
`include "pld_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module pld_detector_tb;
  import pld_pkg::*;
  localparam int Q = 20; // short lock period keeps the run brief
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  pld_meas_type meas_i = '0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rd_data_o;
  logic locked_o;
  logic phase_lost_o;
  logic irq_o;
  logic [7:0] rv;
  int num_errors = 0;
  int checks = 0;

  pld_detector #(.LOCK_QUAL_CYCLES(Q)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .meas_i(meas_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .locked_o(locked_o), .phase_lost_o(phase_lost_o), .irq_o(irq_o)
  );

  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////////////
  // compare, count, report at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 rv = rd_data_o;
  endtask

  // apply a measurement, loss flag is judged two edges later
  task automatic put(input int f, input int u, input logic exp);
    @(posedge clk_sys_i);
    meas_i.fine_err <= 16'(f);
    meas_i.ui_err <= 16'(u);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(8'(phase_lost_o), 8'(exp));
  endtask

  task automatic wait_irq(input logic exp);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(8'(irq_o), 8'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(`PLD_ADDR_FINE);
    chk(rv, 8'ha2);
    rd(`PLD_ADDR_COARSE);
    chk(rv, 8'h85);
    rd(8'h90);
    chk(rv, 8'h00);
    $display("reset test done");
  endtask

  // each size code, both signs, edge of the window and one past it
  task automatic t_fine;
    int w;
    for (int c = 1; c < 8; c++) begin
      wr(`PLD_ADDR_FINE, 8'ha0 | 8'(c));
      w = c * `PLD_WIN_STEP;
      put(w, 0, 1'b0);
      put(w + 1, 0, 1'b1);
      put(-w, 0, 1'b0);
      put(-w - 1, 0, 1'b1);
    end
    wr(`PLD_ADDR_FINE, 8'ha0);
    put(0, 0, 1'b1);
    wr(`PLD_ADDR_FINE, 8'h22);
    put(1000, 0, 1'b0);
    wr(`PLD_ADDR_FINE, 8'ha2);
    $display("fine window test done");
  endtask

  // limit counted in whole input cycles
  task automatic t_coarse;
    int lim[3] = '{0, 5, 15};
    foreach (lim[i]) begin
      wr(`PLD_ADDR_COARSE, 8'h80 | 8'(lim[i]));
      put(0, lim[i], 1'b0);
      put(0, lim[i] + 1, 1'b1);
      put(0, -lim[i] - 1, 1'b1);
    end
    wr(`PLD_ADDR_COARSE, 8'h0f);
    put(0, 100, 1'b0);
    rd(`PLD_ADDR_COARSE);
    chk(rv, 8'h0f);
    wr(`PLD_ADDR_COARSE, 8'h85);
    $display("coarse test done");
  endtask

  // lock after the period, then status, mask and clear
  task automatic t_lock;
    put(0, 0, 1'b0);
    wr(`PLD_ADDR_CLR, 8'h03);
    repeat (Q - 6) @(posedge clk_sys_i);
    #1 chk(8'(locked_o), 8'h00);
    repeat (10) @(posedge clk_sys_i);
    #1 chk(8'(locked_o), 8'h01);
    rd(`PLD_ADDR_STAT);
    chk(rv, 8'h01);
    wr(`PLD_ADDR_IEN, 8'h01);
    wait_irq(1'b1);
    wr(`PLD_ADDR_IEN, 8'h02);
    wait_irq(1'b0);
    put(200, 0, 1'b1);
    chk(8'(locked_o), 8'h00);
    rd(`PLD_ADDR_STAT);
    chk(rv, 8'h03);
    wait_irq(1'b1);
    wr(`PLD_ADDR_CLR, 8'h02);
    rd(`PLD_ADDR_STAT);
    chk(rv, 8'h01);
    wait_irq(1'b0);
    rd(`PLD_ADDR_CLR);
    chk(rv, 8'h00);
    rd(`PLD_ADDR_IEN);
    chk(rv, 8'h02);
    $display("lock and irq test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_fine();
    t_coarse();
    t_lock();
    print_verdict();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule // pld_detector_tb
`default_nettype wire

// *** pld_pkg.sv ***
/*
 * types of the phase loss detector.
 * assumes nothing beyond the defines header.
 */
package pld_pkg;
  typedef struct packed {
    logic signed [15:0] fine_err;
    logic signed [15:0] ui_err;
  } pld_meas_type;
  typedef enum logic [1:0] {
    PLD_LOST = 2'b00,
    PLD_QUAL = 2'b01,
    PLD_LOCKED = 2'b10
  } pld_state_type;
endpackage
